// ### hdl/wwt_write_timing.sv
// External write cycle lead/active/trail timing generator with register port
//
// The implementer's own choices: the strobed register port and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "wwt_map.svh"

// Overview of operation
// - After reset the active wait field is 7, doubled: fourteen cycles of wait.
// - Active phase lasts one cycle plus the active field's wait states, bits 4:2.
// - Trail wait count comes from bits 1:0; codes 1-3 give 1-3 cycles undoubled.
// - With doubling set, trail codes 1, 2, 3 give 2, 4, 6 cycles.
// - After reset the trail field is 3 with doubling: six trail cycles.
// - Lead lasts the bits 6:5 count, doubled when selected; reset gives six.
module wwt_write_timing (
    // Clock and reset
    input  wire logic              ref_clk_i,
    input  wire logic              rstn_i,
    // Register port
    input  wire wwt_pkg::wwt_bus_req_t bus_i,
    output logic [31:0]            rdata_o,
    // Write cycle request
    input  wire logic              wr_start_i,
    output logic                   wr_ready_o,
    // Phase outputs
    output logic                   wr_busy_o,
    output logic                   lead_o,
    output logic                   active_o,
    output logic                   trail_o,
    output logic                   wr_done_o
);
    import wwt_pkg::*;

    logic       rst_meta;
    logic       rst_n;
    wwt_state_t st;
    wwt_state_t next_st;
    logic [3:0] lead_len;
    logic [3:0] act_len;
    logic [3:0] trail_len;

    // Reset release through two flops
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // Phase lengths in ref_clk_i cycles
    always_comb begin
        lead_len  = {2'h0, st.write_lead_wait} << st.double_wait_select;
        act_len   = 4'h1 + ({1'b0, st.write_active_wait} << st.double_wait_select);
        trail_len = {2'h0, st.write_trail_wait} << st.double_wait_select;
    end

    always_comb begin
        next_st       = st;
        next_st.done  = 1'b0;
        next_st.rdata = 32'h0;
        if (bus_i.wr && bus_i.addr == `WWT_TIMING_OFS) begin
            next_st.write_trail_wait   = bus_i.wdata[`WWT_TRAIL_MSB:`WWT_TRAIL_LSB];
            next_st.write_active_wait  = bus_i.wdata[`WWT_ACTIVE_MSB:`WWT_ACTIVE_LSB];
            next_st.write_lead_wait    = bus_i.wdata[`WWT_LEAD_MSB:`WWT_LEAD_LSB];
            next_st.double_wait_select = bus_i.wdata[`WWT_DOUBLE_BIT];
        end
        if (bus_i.rd) begin
            case (bus_i.addr)
                `WWT_TIMING_OFS: begin
                    next_st.rdata = {24'h0, st.double_wait_select, st.write_lead_wait,
                                     st.write_active_wait, st.write_trail_wait};
                end
                `WWT_STATUS_OFS: begin
                    next_st.rdata = {29'h0, st.phase, st.phase != WWT_IDLE};
                end
                default: begin
                    next_st.rdata = 32'h0;
                end
            endcase
        end
        // Sequencer, lengths latched at start so register writes cannot disturb a cycle
        case (st.phase)
            WWT_IDLE: begin
                if (wr_start_i) begin
                    next_st.lat_lead   = lead_len;
                    next_st.lat_active = act_len;
                    next_st.lat_trail  = trail_len;
                    if (lead_len != 4'h0) begin
                        next_st.phase = WWT_LEAD;
                        next_st.cnt   = lead_len - 4'h1;
                    end else begin
                        next_st.phase = WWT_ACTIVE;
                        next_st.cnt   = act_len - 4'h1;
                    end
                end
            end
            WWT_LEAD: begin
                if (st.cnt == 4'h0) begin
                    next_st.phase = WWT_ACTIVE;
                    next_st.cnt   = st.lat_active - 4'h1;
                end else begin
                    next_st.cnt = st.cnt - 4'h1;
                end
            end
            WWT_ACTIVE: begin
                if (st.cnt != 4'h0) begin
                    next_st.cnt = st.cnt - 4'h1;
                end else if (st.lat_trail != 4'h0) begin
                    next_st.phase = WWT_TRAIL;
                    next_st.cnt   = st.lat_trail - 4'h1;
                end else begin
                    next_st.phase = WWT_IDLE;
                    next_st.done  = 1'b1;
                end
            end
            WWT_TRAIL: begin
                if (st.cnt == 4'h0) begin
                    next_st.phase = WWT_IDLE;
                    next_st.done  = 1'b1;
                end else begin
                    next_st.cnt = st.cnt - 4'h1;
                end
            end
            default: begin
                next_st.phase = WWT_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            st                    <= '0;
            st.phase              <= WWT_IDLE;
            st.write_lead_wait    <= `WWT_LEAD_RST;
            st.write_active_wait  <= `WWT_ACTIVE_RST;
            st.write_trail_wait   <= `WWT_TRAIL_RST;
            st.double_wait_select <= `WWT_DOUBLE_RST;
        end else begin
            st <= next_st;
        end
    end

    assign rdata_o    = st.rdata;
    assign wr_ready_o = st.phase == WWT_IDLE;
    assign wr_busy_o  = st.phase != WWT_IDLE;
    assign lead_o     = st.phase == WWT_LEAD;
    assign active_o   = st.phase == WWT_ACTIVE;
    assign trail_o    = st.phase == WWT_TRAIL;
    assign wr_done_o  = st.done;

    // Checking helpers
    logic       cfg_written;
    logic [3:0] phase_cyc;
    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            cfg_written <= 1'b0;
            phase_cyc   <= 4'h0;
        end else begin
            if (bus_i.wr && bus_i.addr == `WWT_TIMING_OFS) begin
                cfg_written <= 1'b1;
            end
            phase_cyc <= (next_st.phase != st.phase) ? 4'h1 : phase_cyc + 4'h1;
        end
    end

    sequence s_leave_active;
        active_o ##1 !active_o;
    endsequence
    sequence s_enter_trail;
        !trail_o ##1 trail_o;
    endsequence

    property p_rst_active;
        @(posedge ref_clk_i) disable iff (!rst_n)
        !cfg_written |-> st.write_active_wait == 3'h7 && st.double_wait_select
            && act_len == 4'hf;
    endproperty
    a_rst_active: assert property (p_rst_active) else $error("active reset value wrong");

    property p_active_len;
        @(posedge ref_clk_i) disable iff (!rst_n)
        (active_o && next_st.phase != WWT_ACTIVE) |-> phase_cyc == st.lat_active;
    endproperty
    a_active_len: assert property (p_active_len) else $error("active length wrong");

    property p_trail_single;
        @(posedge ref_clk_i) disable iff (!rst_n)
        (wr_ready_o && wr_start_i && !st.double_wait_select)
            |=> st.lat_trail == {2'h0, $past(st.write_trail_wait)};
    endproperty
    a_trail_single: assert property (p_trail_single) else $error("trail count wrong");

    property p_trail_double;
        @(posedge ref_clk_i) disable iff (!rst_n)
        (trail_o && next_st.phase != WWT_TRAIL && st.lat_trail != 4'h0)
            |-> phase_cyc == st.lat_trail;
    endproperty
    a_trail_double: assert property (p_trail_double) else $error("trail length wrong");

    // Doubled trail load: code shifted up one place
    property p_trail_dbl;
        @(posedge ref_clk_i) disable iff (!rst_n)
        (wr_ready_o && wr_start_i && st.double_wait_select)
            |=> st.lat_trail == {1'b0, $past(st.write_trail_wait), 1'b0};
    endproperty
    a_trail_dbl: assert property (p_trail_dbl) else $error("doubled trail count wrong");

    property p_rst_trail;
        @(posedge ref_clk_i) disable iff (!rst_n)
        !cfg_written |-> st.write_trail_wait == 2'h3 && trail_len == 4'h6;
    endproperty
    a_rst_trail: assert property (p_rst_trail) else $error("trail reset value wrong");

    property p_lead_len;
        @(posedge ref_clk_i) disable iff (!rst_n)
        (lead_o && next_st.phase != WWT_LEAD) |-> phase_cyc == st.lat_lead;
    endproperty
    a_lead_len: assert property (p_lead_len) else $error("lead length wrong");

    property p_order;
        @(posedge ref_clk_i) disable iff (!rst_n)
        s_enter_trail |-> $past(active_o);
    endproperty
    a_order: assert property (p_order) else $error("trail not after active");

    property p_done_after;
        @(posedge ref_clk_i) disable iff (!rst_n)
        s_leave_active |-> trail_o || wr_done_o;
    endproperty
    a_done_after: assert property (p_done_after) else $error("active not followed");

endmodule : wwt_write_timing
`default_nettype wire

// ### hdl/wwt_map.svh
// Register offsets, field positions, reset values and widths of the write timing block
`ifndef WWT_MAP_SVH
`define WWT_MAP_SVH

`define WWT_ADDR_W          8
`define WWT_DATA_W          32
`define WWT_CNT_W           4

`define WWT_TIMING_OFS      8'h00
`define WWT_STATUS_OFS      8'h04

`define WWT_TRAIL_LSB       0
`define WWT_TRAIL_MSB       1
`define WWT_ACTIVE_LSB      2
`define WWT_ACTIVE_MSB      4
`define WWT_LEAD_LSB        5
`define WWT_LEAD_MSB        6
`define WWT_DOUBLE_BIT      7

`define WWT_TRAIL_RST       2'h3
`define WWT_ACTIVE_RST      3'h7
`define WWT_LEAD_RST        2'h3
`define WWT_DOUBLE_RST      1'h1

`define WWT_STAT_BUSY_BIT   0
`define WWT_STAT_PHASE_LSB  1
`define WWT_STAT_PHASE_MSB  2

`endif

// ### hdl/wwt_pkg.sv
// Types of the write timing block
package wwt_pkg;

    typedef enum logic [1:0] {
        WWT_IDLE   = 2'b00,
        WWT_LEAD   = 2'b01,
        WWT_ACTIVE = 2'b10,
        WWT_TRAIL  = 2'b11
    } wwt_phase_t;

    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } wwt_bus_req_t;

    typedef struct packed {
        wwt_phase_t  phase;
        logic [3:0]  cnt;
        logic [1:0]  write_lead_wait;
        logic [2:0]  write_active_wait;
        logic [1:0]  write_trail_wait;
        logic        double_wait_select;
        logic [3:0]  lat_lead;
        logic [3:0]  lat_active;
        logic [3:0]  lat_trail;
        logic        done;
        logic [31:0] rdata;
    } wwt_state_t;

endpackage : wwt_pkg

// ### bench/wwt_ext_dev.sv
// Far-side device model that times each external write it sees
`timescale 1ns/10ps
`default_nettype none
module wwt_ext_dev (
    // Clock
    input  wire logic       clk_i,
    // Write cycle strobes seen at the device
    input  wire logic       lead_i,
    input  wire logic       active_i,
    input  wire logic       trail_i,
    input  wire logic       done_i,
    // Measured phase lengths of the last write
    output logic [7:0]      lead_len_o,
    output logic [7:0]      active_len_o,
    output logic [7:0]      trail_len_o
);
    logic [7:0] nl = 8'h00;
    logic [7:0] na = 8'h00;
    logic [7:0] nt = 8'h00;
    // Counters restart at each end of cycle, so back-to-back writes stay apart
    always_ff @(posedge clk_i) begin
        if (done_i) begin
            lead_len_o   <= nl;
            active_len_o <= na;
            trail_len_o  <= nt;
            nl           <= 8'h00;
            na           <= 8'h00;
            nt           <= 8'h00;
        end else begin
            nl <= nl + {7'h00, lead_i};
            na <= na + {7'h00, active_i};
            nt <= nt + {7'h00, trail_i};
        end
    end
endmodule : wwt_ext_dev
`default_nettype wire

// ### bench/testbench.sv
// Self-checking bench for the write timing block
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin errors++; \
    $display("BAD %s expected %0h seen %0h", n, e, s); end end
module testbench;
    import wwt_pkg::*;
    logic         ref_clk = 1'b0;
    logic         rstn    = 1'b0;
    wwt_bus_req_t bus     = '0;
    logic         start   = 1'b0;
    logic [31:0]  rdata;
    logic         ready, busy, lead, active, trail, done;
    logic [7:0]   ll, al, tl;
    int           errors  = 0;
    int           checks  = 0;
    int           seed    = 39370;
    always #5 ref_clk = ~ref_clk;
    wwt_write_timing DUT (.ref_clk_i(ref_clk), .rstn_i(rstn), .bus_i(bus), .rdata_o(rdata),
        .wr_start_i(start), .wr_ready_o(ready), .wr_busy_o(busy), .lead_o(lead),
        .active_o(active), .trail_o(trail), .wr_done_o(done));
    wwt_ext_dev dev (.clk_i(ref_clk), .lead_i(lead), .active_i(active), .trail_i(trail),
        .done_i(done), .lead_len_o(ll), .active_len_o(al), .trail_len_o(tl));
    function automatic logic [7:0] plen(input logic [2:0] code, input logic d);
        return {5'h00, code} << d;
    endfunction : plen
    task automatic summarize;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : summarize
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge ref_clk);
        bus.wr <= 1'b0;
    endtask : reg_wr
    task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge ref_clk);
        bus.rd <= 1'b0;
        #1 d = rdata;
    endtask : reg_rd
    task automatic run(input logic [1:0] l, input logic [2:0] a, input logic [1:0] t,
                       input logic d);
        int n;
        int tot;
        tot = plen({1'b0, l}, d) + plen(a, d) + 1 + plen({1'b0, t}, d);
        @(posedge ref_clk);
        start <= 1'b1;
        @(posedge ref_clk);
        // Extra held start must be refused while busy
        start <= (tot > 2);
        #1;
        `CHK("busy", 1'b1, busy)
        @(posedge ref_clk);
        start <= 1'b0;
        for (n = 2; n < 200; n++) begin
            #1 if (done === 1'b1) break;
            @(posedge ref_clk);
        end
        if (n == 200) begin
            errors++;
            summarize();
        end
        `CHK("total", tot + 1, n)
        `CHK("ready_at_done", 1'b1, ready)
        `CHK("idle_at_done", 1'b0, busy)
        @(posedge ref_clk);
        #1;
        `CHK("lead_len", plen({1'b0, l}, d), ll)
        `CHK("active_len", plen(a, d) + 8'h01, al)
        `CHK("trail_len", plen({1'b0, t}, d), tl)
        $display("test done lead %0d active %0d trail %0d dbl %0d", l, a, t, d);
    endtask : run
    initial begin
        logic [31:0] v;
        logic [7:0]  c;
        repeat (3) @(posedge ref_clk);
        rstn <= 1'b1;
        repeat (2) @(posedge ref_clk);
        reg_rd(8'h00, v);
        `CHK("timing_rst", 32'h0000_00ff, v)
        reg_rd(8'h04, v);
        `CHK("status_idle", 32'h0, v)
        reg_rd(8'h08, v);
        `CHK("unmapped", 32'h0, v)
        run(2'h3, 3'h7, 2'h3, 1'b1);
        for (int i = 0; i < 24; i++) begin
            c = 8'($random(seed));
            if (i < 6) c = {i[0], c[6:2], 2'(i / 2 + 1)};
            if (i == 6) c[4:2] = 3'h0;
            // Trail code 0 is undefined, software never programs it
            if (c[1:0] == 2'h0) c[1:0] = 2'h1;
            reg_wr(8'h00, {24'h0, c});
            reg_rd(8'h00, v);
            `CHK("timing_rb", c, v[7:0])
            run(c[6:5], c[4:2], c[1:0], c[7]);
        end
        // Second reset after programming must restore the defaults
        @(posedge ref_clk);
        rstn <= 1'b0;
        repeat (3) @(posedge ref_clk);
        rstn <= 1'b1;
        repeat (2) @(posedge ref_clk);
        reg_rd(8'h00, v);
        `CHK("timing_rst2", 32'h0000_00ff, v)
        run(2'h3, 3'h7, 2'h3, 1'b1);
        summarize();
    end
endmodule : testbench
`default_nettype wire
